/* inc/tcl_pkg.sv */
/*
 * tcl_pkg: shared constants and carrier types of the traffic-channel test loop.
 * Assumes a 25 MHz clock and frame timing strobes from the baseband sequencer.
 */
package tcl_pkg;

    // ****************************************************************
    // frame sizes and timing counts
    // ****************************************************************
    localparam int unsigned TCL_FR_BITS       = 260;  // full/half rate speech frame
    localparam int unsigned TCL_EFR_BITS      = 244;  // enhanced full rate frame
    localparam int unsigned TCL_BURST_BITS    = 114;  // information bits per burst
    localparam int unsigned TCL_DATA_W        = 260;  // widest payload carried
    localparam int unsigned TCL_SETUP_FRAMES  = 104;  // loop set-up bound, frames
    localparam int unsigned TCL_RTD_LIMIT     = 26;   // round trip delay ceiling
    localparam logic [4:0]  TCL_RTD_FRAMES    = 5'h05; // implemented round trip delay
    localparam logic [6:0]  TCL_SETUP_RST     = 7'h00;
    localparam int unsigned TCL_FIFO_DEPTH    = 32;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        TCL_LOOP_A,     // erased-frame signalling
        TCL_LOOP_B,     // no erasure signalling
        TCL_LOOP_C,     // burst by burst
        TCL_LOOP_NONE
    } tcl_loop_e;

    typedef enum logic [1:0] {
        TCL_CH_FULLRATE,
        TCL_CH_HALFRATE,
        TCL_CH_ENH_FULLRATE,
        TCL_CH_DATA
    } tcl_chan_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic                  valid;
        tcl_loop_e             loop;
        logic [2:0]            channel;   // traffic channel to be looped
    } tcl_cmd_s;

    typedef struct packed {
        logic [TCL_DATA_W-1:0] bits;      // payload, low bits used
        logic [8:0]            nbits;     // number of valid bits
    } tcl_frame_s;

endpackage

/* rtl/tcl_fifo.sv */
/*
 * tcl_fifo: synchronous valid/ready FIFO, width and depth parameters.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module tcl_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push;
    wire              pop;

    // handshake decode
    assign in_ready_o  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_o = (count_reg != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg];

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* rtl/tcl_test_loop.sv */
/*
 * tcl_test_loop: traffic-channel test loop of the mobile baseband.
 * Assumes command decode upstream delivers close/open requests as pulses,
 * decoder and burst streams arrive on valid/ready, frame strobe once per frame.
 */
`timescale 1ns/10ps
`default_nettype none
module tcl_test_loop
    import tcl_pkg::*;
#(
    parameter int unsigned DEPTH = TCL_FIFO_DEPTH
) (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire tcl_cmd_s        close_loop_request_i,
    input  wire logic            open_loop_i,
    input  wire logic            power_off_i,
    input  wire logic            test_card_present_i,
    input  wire logic            traffic_active_i,
    input  wire logic            audio_test_request_i,
    input  wire tcl_chan_e       chan_type_i,
    // downlink decoder frames
    input  wire logic            dec_valid_i,
    output logic                 dec_ready_o,
    input  wire tcl_frame_s      dec_frame_i,
    input  wire logic            dec_bad_i,
    input  wire logic            dec_facch_i,
    // downlink bursts
    input  wire logic            burst_valid_i,
    output logic                 burst_ready_o,
    input  wire logic [113:0]    burst_bits_i,
    input  wire logic            burst_traffic_i,
    // frame timing
    input  wire logic            frame_strobe_i,
    input  wire logic            ul_sacch_slot_i,
    // uplink encoder input
    output logic                 enc_valid_o,
    input  wire logic            enc_ready_i,
    output tcl_frame_s           enc_frame_o,
    output logic                 enc_burst_o,
    output logic                 own_training_o,
    // status
    output logic                 close_loop_confirm_o,
    output tcl_loop_e            loop_mode_o,
    output logic [2:0]           loop_channel_o,
    output logic                 audio_test_on_o,
    output logic                 loop_c_ready_o,
    output logic [4:0]           round_trip_delay_o
);

    localparam int unsigned FW = $bits(tcl_frame_s) + 1;

    // ****************************************************************
    // loop control
    // ****************************************************************
    typedef enum logic [1:0] { TCL_ST_OPEN, TCL_ST_CLOSED, TCL_ST_AUDIO } tcl_state_e;

    tcl_state_e state_reg;
    tcl_state_e state_next;
    tcl_loop_e  mode_reg;
    logic [2:0] chan_reg;
    logic       confirm_reg;
    logic       c_ready_reg;

    wire close_ok;
    wire kill;

    assign kill     = power_off_i | ~test_card_present_i | open_loop_i;
    // ignore when idle channel or closed
    assign close_ok = close_loop_request_i.valid & traffic_active_i
                      & (state_reg == TCL_ST_OPEN)
                      & (close_loop_request_i.loop != TCL_LOOP_NONE);

    // next state, exclusion and hold
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TCL_ST_OPEN: begin
                if (kill) begin
                    state_next = TCL_ST_OPEN;
                end else if (close_ok) begin
                    state_next = TCL_ST_CLOSED;
                end else if (audio_test_request_i) begin
                    state_next = TCL_ST_AUDIO;
                end
            end
            TCL_ST_CLOSED: begin
                if (kill) begin
                    state_next = TCL_ST_OPEN;
                end
            end
            TCL_ST_AUDIO: begin
                if (kill) begin
                    state_next = TCL_ST_OPEN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg   <= TCL_ST_OPEN;
            mode_reg    <= TCL_LOOP_NONE;
            chan_reg    <= 3'h0;
            confirm_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            confirm_reg <= close_ok & ~kill;
            if (close_ok & ~kill) begin
                mode_reg <= close_loop_request_i.loop;
                chan_reg <= close_loop_request_i.channel;
            end else if (state_next == TCL_ST_OPEN) begin
                mode_reg <= TCL_LOOP_NONE;
            end
        end
    end

    // burst loop ready well inside 104 frames
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_reg != TCL_ST_CLOSED) begin
            c_ready_reg   <= 1'b0;
        end else if (mode_reg == TCL_LOOP_C && frame_strobe_i && !c_ready_reg) begin
            c_ready_reg   <= 1'b1;   // one frame suffices
        end
    end

    // ****************************************************************
    // data path
    // ****************************************************************
    wire        loop_a;
    wire        loop_b;
    wire        loop_c;
    wire        zero_frame;
    wire        take_frame;
    wire        take_burst;
    wire [8:0]  frame_len;
    tcl_frame_s frame_sel;
    tcl_frame_s burst_frame;
    wire        fifo_in_valid;
    wire        fifo_in_ready;
    wire [FW-1:0] fifo_in_data;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [FW-1:0] fifo_out_data;
    wire        enc_take;
    wire        enc_load;

    // payload length by channel type
    function automatic logic [8:0] frame_bits(input tcl_chan_e ch);
        if (ch == TCL_CH_ENH_FULLRATE) begin
            return 9'(TCL_EFR_BITS);
        end
        return 9'(TCL_FR_BITS);
    endfunction

    assign loop_a     = (state_reg == TCL_ST_CLOSED) && (mode_reg == TCL_LOOP_A);
    assign loop_b     = (state_reg == TCL_ST_CLOSED) && (mode_reg == TCL_LOOP_B);
    assign loop_c     = (state_reg == TCL_ST_CLOSED) && (mode_reg == TCL_LOOP_C) && c_ready_reg;
    assign frame_len  = frame_bits(chan_type_i);
    assign zero_frame = loop_a & dec_bad_i & (chan_type_i != TCL_CH_DATA);
    // frames looped, fast signalling left to its own path
    assign take_frame = dec_valid_i & ~dec_facch_i & (loop_a | loop_b);
    assign take_burst = burst_valid_i & burst_traffic_i & loop_c;

    always_comb begin
        frame_sel       = dec_frame_i;
        frame_sel.nbits = frame_len;
        frame_sel.bits  = dec_frame_i.bits & ~({TCL_DATA_W{1'b1}} << frame_len);
        if (zero_frame) begin
            frame_sel.bits = '0;
        end
        burst_frame       = '0;
        burst_frame.bits  = TCL_DATA_W'(burst_bits_i);
        burst_frame.nbits = 9'(TCL_BURST_BITS);
    end

    assign fifo_in_valid = take_frame | take_burst;
    assign fifo_in_data  = take_burst ? {1'b1, burst_frame} : {1'b0, frame_sel};
    assign dec_ready_o   = fifo_in_ready | ~(loop_a | loop_b);
    assign burst_ready_o = fifo_in_ready | ~loop_c;
    // hold looped frames and bursts during uplink control slot
    assign enc_take       = enc_valid_o & enc_ready_i;
    assign enc_load       = (~enc_valid_o | enc_ready_i) & ~ul_sacch_slot_i;
    assign fifo_out_ready = enc_load;

    tcl_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // ****************************************************************
    // uplink output stage
    // ****************************************************************
    tcl_frame_s enc_frame_reg;
    logic       enc_valid_reg;
    logic       enc_burst_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            enc_valid_reg <= 1'b0;
            enc_frame_reg <= '0;
            enc_burst_reg <= 1'b0;
        end else if (enc_load) begin
            enc_valid_reg <= fifo_out_valid;
            enc_frame_reg <= fifo_out_data[FW-2:0];
            enc_burst_reg <= fifo_out_data[FW-1];
        end else if (enc_take) begin
            enc_valid_reg <= 1'b0;   // word taken, nothing new in control slot
        end
    end

    // status registers
    logic       audio_reg;
    logic [4:0] rtd_reg;
    logic       training_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            audio_reg    <= 1'b0;
            rtd_reg      <= 5'h00;
            training_reg <= 1'b0;
        end else begin
            audio_reg    <= (state_next == TCL_ST_AUDIO);
            rtd_reg      <= TCL_RTD_FRAMES;
            training_reg <= 1'b1;
        end
    end

    assign enc_valid_o          = enc_valid_reg;
    assign enc_frame_o          = enc_frame_reg;
    assign enc_burst_o          = enc_burst_reg;
    assign own_training_o       = training_reg;
    assign close_loop_confirm_o = confirm_reg;
    assign loop_mode_o          = mode_reg;
    assign loop_channel_o       = chan_reg;
    assign audio_test_on_o      = audio_reg;
    assign loop_c_ready_o       = c_ready_reg;
    assign round_trip_delay_o   = rtd_reg;

endmodule
`default_nettype wire

/* verif/tcl_test_loop_sva.sv */
/* tcl_test_loop_sva: port checker of the test loop.
   Assumes tcl_pkg and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module tcl_test_loop_sva
    import tcl_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire tcl_cmd_s   close_loop_request_i,
    input wire logic       open_loop_i,
    input wire logic       power_off_i,
    input wire logic       test_card_present_i,
    input wire logic       traffic_active_i,
    input wire tcl_chan_e  chan_type_i,
    input wire logic       enc_valid_o,
    input wire logic       enc_ready_i,
    input wire logic       ul_sacch_slot_i,
    input wire tcl_frame_s enc_frame_o,
    input wire logic       enc_burst_o,
    input wire logic       close_loop_confirm_o,
    input wire tcl_loop_e  loop_mode_o,
    input wire logic       audio_test_on_o,
    input wire logic [4:0] round_trip_delay_o
);
    // ******
    // causes
    // ******
    wire       kill = open_loop_i || power_off_i || !test_card_present_i;
    wire       take = close_loop_request_i.valid && traffic_active_i && !kill
        && loop_mode_o == TCL_LOOP_NONE && !audio_test_on_o
        && close_loop_request_i.loop != TCL_LOOP_NONE;
    wire [8:0] want = enc_burst_o ? 9'h072
        : (chan_type_i == TCL_CH_ENH_FULLRATE ? 9'h0F4 : 9'h104);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ******
    // checks
    // ******
    a_confirm_on_close: assert property (
        take |=> close_loop_confirm_o && loop_mode_o == $past(close_loop_request_i.loop))
        else $error("close request not confirmed");
    a_ignore_refused: assert property (
        close_loop_request_i.valid && (!traffic_active_i || loop_mode_o != TCL_LOOP_NONE)
        |=> !close_loop_confirm_o) else $error("refused request confirmed");
    a_confirm_cause: assert property (
        close_loop_confirm_o |-> $past(take)) else $error("confirm without request");
    a_loop_holds: assert property (
        loop_mode_o != TCL_LOOP_NONE && !kill |=> loop_mode_o == $past(loop_mode_o))
        else $error("closed loop changed");
    a_kill_opens: assert property (
        kill |=> loop_mode_o == TCL_LOOP_NONE && !audio_test_on_o)
        else $error("test function left active");
    a_mode_exclusive: assert property (
        !(audio_test_on_o && loop_mode_o != TCL_LOOP_NONE)) else $error("loop with audio test");
    a_rtd_declared: assert property (
        $past(rst_n_i) |-> round_trip_delay_o == TCL_RTD_FRAMES && round_trip_delay_o < 26)
        else $error("round trip delay wrong");
    a_frame_length: assert property (
        enc_valid_o |-> enc_frame_o.nbits == want && (enc_frame_o.bits >> want) == '0)
        else $error("uplink length wrong");
    a_valid_holds: assert property (
        enc_valid_o && !enc_ready_i |=> enc_valid_o && $stable(enc_frame_o))
        else $error("uplink dropped while stalled");
    a_sacch_holds: assert property (
        ul_sacch_slot_i && (!enc_valid_o || enc_ready_i) |=> !enc_valid_o)
        else $error("uplink word issued in control slot");
endmodule
bind tcl_test_loop tcl_test_loop_sva chk_u (.clk_i, .rst_n_i, .close_loop_request_i,
    .open_loop_i, .power_off_i, .test_card_present_i, .traffic_active_i, .chan_type_i,
    .enc_valid_o, .enc_ready_i, .ul_sacch_slot_i, .enc_frame_o, .enc_burst_o,
    .close_loop_confirm_o, .loop_mode_o, .audio_test_on_o, .round_trip_delay_o);
`default_nettype wire

/* verif/tcl_uplink_model.sv */
/* tcl_uplink_model: uplink sink that stands for the simulator side.
   Assumes the encoder stream of the test loop, valid/ready. */
`timescale 1ns/10ps
`default_nettype none
module tcl_uplink_model
    import tcl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       hold_i,
    input  wire logic       enc_valid_i,
    input  wire tcl_frame_s enc_frame_i,
    input  wire logic       enc_burst_i,
    output logic            enc_ready_o,
    output logic            got_o,
    output tcl_frame_s      got_frame_o,
    output logic            got_burst_o
);
    initial {enc_ready_o, got_o} = 2'b00;
    // accept at random pace, stall fully on hold
    always @(posedge clk_i) begin
        got_o <= enc_valid_i && enc_ready_o;
        got_frame_o <= enc_frame_i;
        got_burst_o <= enc_burst_i;
        enc_ready_o <= !hold_i && ($urandom_range(3) != 0);
    end
endmodule
`default_nettype wire

/* verif/tcl_test_loop_tb.sv */
/* tcl_test_loop_tb: self-checking bench of the test loop.
   Assumes tcl_pkg, the loop design with its checker, and the uplink model. */
`timescale 1ns/10ps
`default_nettype none
module tcl_test_loop_tb;
    import tcl_pkg::*;
    logic clk_i = 0, rst_n_i = 0, open = 0, poff = 0, card = 1, trf = 0, aud = 0;
    logic dv = 0, dbad = 0, bv = 0, btrf = 0, strobe = 0, sacch = 0, hold = 0, dfac = 0;
    logic dr, br, ev, er, eb, own, conf, aon, cready, got, gb;
    logic [113:0] bbits = '0;
    logic [2:0] lch;
    logic [4:0] round_trip_delay;
    tcl_cmd_s req = '0;
    tcl_chan_e chan = TCL_CH_FULLRATE;
    tcl_frame_s df = '0, ef, gf;
    tcl_loop_e mode;
    logic [269:0] exp_q[$];
    int checked = 0, bad_count = 0;
    always #20 clk_i = ~clk_i;
    tcl_test_loop #(.DEPTH(4)) uut (.clk_i, .rst_n_i, .close_loop_request_i(req),
        .open_loop_i(open), .power_off_i(poff), .test_card_present_i(card),
        .traffic_active_i(trf), .audio_test_request_i(aud), .chan_type_i(chan),
        .dec_valid_i(dv), .dec_ready_o(dr), .dec_frame_i(df), .dec_bad_i(dbad),
        .dec_facch_i(dfac), .burst_valid_i(bv), .burst_ready_o(br), .burst_bits_i(bbits),
        .burst_traffic_i(btrf), .frame_strobe_i(strobe), .ul_sacch_slot_i(sacch),
        .enc_valid_o(ev), .enc_ready_i(er), .enc_frame_o(ef), .enc_burst_o(eb),
        .own_training_o(own), .close_loop_confirm_o(conf), .loop_mode_o(mode),
        .loop_channel_o(lch), .audio_test_on_o(aon), .loop_c_ready_o(cready),
        .round_trip_delay_o(round_trip_delay));
    tcl_uplink_model far_u (.clk_i, .hold_i(hold), .enc_valid_i(ev), .enc_frame_i(ef),
        .enc_burst_i(eb), .enc_ready_o(er), .got_o(got), .got_frame_o(gf), .got_burst_o(gb));
    // ******
    // checking
    // ******
    task automatic chk(input string nm, input logic [269:0] seen, input logic [269:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [269:0] expect_of(logic b, logic [259:0] d, logic bad);
        logic [8:0] nb;
        nb = b ? 9'h072 : (chan == TCL_CH_ENH_FULLRATE ? 9'h0F4 : 9'h104);
        d = d & ({260{1'b1}} >> (260 - nb));
        if (!b && bad && mode == TCL_LOOP_A && chan != TCL_CH_DATA) d = '0;
        return {b, d, nb};
    endfunction
    always @(negedge clk_i) if (got === 1'b1) begin
        if (exp_q.size() == 0) chk("extra uplink", 1, 0);
        else chk("uplink", {gb, gf}, exp_q.pop_front());
    end
    // ******
    // drivers
    // ******
    task automatic put(input logic b, input logic bad, input logic t);
        logic [287:0] r;
        logic acc;
        int n;
        for (n = 0; n < 9; n++) r = {r[255:0], $urandom};
        {dv, bv, dbad, btrf, sacch} = {!b, b, bad, t, r[287:285] == 3'h0};
        // fast signalling downlink only in loop A, never in loop B
        dfac = !b && mode == TCL_LOOP_A && r[284:282] == 3'h0;
        df = {r[259:0], 9'h104};
        bbits = r[113:0];
        n = 0;
        do begin
            @(negedge clk_i);
            acc = b ? br : dr;
            @(posedge clk_i);
            #1 n++;
        end while (acc !== 1'b1 && n < 300);
        if (acc !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        if (b ? t && mode == TCL_LOOP_C : mode != TCL_LOOP_C && !dfac)
            exp_q.push_back(expect_of(b, r[259:0], bad));
        {dv, bv, sacch, dfac} = 4'h0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic close(input tcl_loop_e l, input logic ok);
        tcl_loop_e was;
        int guard;
        was = mode;
        req = {1'b1, l, 3'($urandom)};
        @(posedge clk_i);
        #1 req.valid = 1'b0;
        // guard timer runs from the request until the confirm shows
        for (guard = 0; guard < 8 && conf !== 1'b1; guard++) begin
            @(posedge clk_i);
            #1;
        end
        chk("guard timer", guard, ok ? 0 : 8);
        chk("confirm", conf, ok);
        chk("mode", mode, ok ? l : was);
        if (ok) chk("channel", lch, req.channel);
        @(posedge clk_i);
        #1;
    endtask
    task automatic kill(input int k);
        {open, poff, card} = {k == 0, k == 1, k != 2};
        @(posedge clk_i);
        #1 {open, poff, card} = 3'b001;
        @(negedge clk_i);
        chk("opened", mode, TCL_LOOP_NONE);
        @(posedge clk_i);
        #1;
    endtask
    // ******
    // main sequence
    // ******
    initial begin
        void'($urandom(32'h6889db22));
        repeat (4) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        chk("reset mode", mode, TCL_LOOP_NONE);
        close(TCL_LOOP_A, 1'b0);
        trf = 1'b1;
        close(TCL_LOOP_NONE, 1'b0);
        for (int m = 0; m < 3; m++) for (int c = 0; c < 4; c++) begin
            chan = tcl_chan_e'(c);
            close(tcl_loop_e'(m), 1'b1);
            close(TCL_LOOP_B, 1'b0);
            if (m == 2) begin
                strobe = 1'b1;
                @(posedge clk_i);
                #1 strobe = 1'b0;
                chk("loop c ready", cready, 1'b1);
                chk("delay", round_trip_delay, TCL_RTD_FRAMES);
            end
            // stall the uplink until the buffer pushes back
            if (m == 1 && c == 0) begin
                hold = 1'b1;
                for (int n = 0; n < 12 && dr === 1'b1; n++) put(1'b0, 1'b0, 1'b0);
                chk("buffer full", dr, 1'b0);
                hold = 1'b0;
            end
            aud = (c == 1);
            repeat (6) put(m == 2, 1'($urandom), 1'($urandom));
            for (int n = 0; n < 600 && exp_q.size() > 0; n++) @(posedge clk_i);
            #1 chk("drained", exp_q.size(), 0);
            chk("audio refused", aon, 1'b0);
            chk("burst ready", br, 1'b1);
            aud = 1'b0;
            chk("training", own, 1'b1);
            kill(c % 3);
        end
        aud = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk("audio on", aon, 1'b1);
        close(TCL_LOOP_A, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
